/* File: rtl/bagu_pkg.sv */
// Purpose: Shared constants and types of the bit and I/O address unit
// Assumes: 32-bit APB data, 16-bit pointers and I/O words
// Notes: Register offsets are byte addresses, one aligned word each
package bagu_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PTR_W = 16;
  localparam int PAGE_W = 9;
  localparam int POFS_W = 7;
  localparam int WORD_W = 16;
  localparam int SRC_W = 32;
  localparam int BIDX_W = 5;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COEF_PTR = 8'h04;
  localparam logic [7:0] OFS_BUF_START = 8'h08;
  localparam logic [7:0] OFS_PAGE_PTR = 8'h0c;
  localparam logic [7:0] OFS_ACC_TWO = 8'h10;
  localparam logic [7:0] OFS_STATUS0 = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_IO_ADDR = 8'h1c;
  localparam logic [7:0] OFS_BIT_ADDR = 8'h20;
  localparam logic [7:0] OFS_IO_DATA = 8'h24;
  localparam logic [7:0] OFS_UNIT_STAT = 8'h28;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CIRC_BIT = 0;
  localparam int ST0_TF1_BIT = 0;
  localparam int ST0_TF2_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REFUSED_BIT = 1;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int CMD_QUAL_BIT = 4;
  localparam int CMD_WRITE_BIT = 5;
  localparam int CMD_PAR_BIT = 6;
  localparam int CMD_POFS_LSB = 8;
  localparam int CMD_EXT_LSB = 16;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 9'h000;
  localparam logic [SRC_W-1:0] SRC_RST = 32'h0000_0000;
  localparam logic [BIDX_W-1:0] BIDX_ONE = 5'h01;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_BIT_CLR_OFS = 3'b001,
    OP_BIT_CLR_PRE = 3'b010,
    OP_BIT_TST_OFS = 3'b011,
    OP_BIT_TST_PRE = 3'b100,
    OP_IO_ABS = 3'b101,
    OP_IO_DIR = 3'b110,
    OP_IO_IND = 3'b111
  } bagu_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } bagu_state_t;

  typedef struct packed {
    logic req;
    logic io_space;
    logic we;
    logic [PTR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } bagu_mem_req_t;
endpackage : bagu_pkg

/* File: rtl/bagu_top.sv */
// Purpose: Bit address and I/O word address generation behind an APB slave
// Assumes: Memory/I/O responder runs on pclk and answers with a one-cycle ack
// Notes: Software issues an instruction by writing the command register
//
// What this block does
// - Offset form: pointer plus offset, plus start when circular
// - Offset from extension; never issued in parallel
// - Pre-modify: pointer updated, then used as address
// - Pair test copies two bits into flags
// - Bit clear zeroes only the addressed bit
// - Absolute, direct, indirect I/O addressing supported
// - Absolute form goes to I/O, constant address
// - Absolute constant from extension; no parallel issue
// - Direct: page pointer high, seven-bit offset low
// - Offset 0 first, 127 last page word
// - One 16-bit word per I/O access
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
module bagu_top
  import bagu_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory and I/O access port
  output bagu_mem_req_t mem_req,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_ack
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [PTR_W-1:0] lin_or_circ(input logic [PTR_W-1:0] base,
                                                   input logic circ,
                                                   input logic [PTR_W-1:0] start);
    lin_or_circ = circ ? PTR_W'(base + start) : base;
  endfunction : lin_or_circ

  function automatic logic uses_ext(input bagu_op_t op);
    uses_ext = (op != OP_NONE) && (op != OP_IO_DIR) && (op != OP_IO_IND);
  endfunction : uses_ext

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic circ_en;
  logic [PTR_W-1:0] coefficient_pointer;
  logic [PTR_W-1:0] coeff_buffer_start;
  logic [PAGE_W-1:0] peripheral_page_pointer;
  logic [SRC_W-1:0] accumulator_two;
  logic test_flag_one;
  logic test_flag_two;
  logic refused;
  logic [PTR_W-1:0] last_io_addr;
  logic [PTR_W-1:0] last_bit_addr;
  logic [WORD_W-1:0] io_data;
  bagu_state_t state;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire [7:0] boff = 8'(paddr);
  wire sel_ctrl = (boff == OFS_CTRL);
  wire sel_ptr = (boff == OFS_COEF_PTR);
  wire sel_bsa = (boff == OFS_BUF_START);
  wire sel_page = (boff == OFS_PAGE_PTR);
  wire sel_acc = (boff == OFS_ACC_TWO);
  wire sel_st0 = (boff == OFS_STATUS0);
  wire sel_cmd = (boff == OFS_CMD);
  wire sel_ioa = (boff == OFS_IO_ADDR);
  wire sel_bta = (boff == OFS_BIT_ADDR);
  wire sel_iod = (boff == OFS_IO_DATA);
  wire sel_stat = (boff == OFS_UNIT_STAT);
  wire mapped = sel_ctrl | sel_ptr | sel_bsa | sel_page | sel_acc | sel_st0 |
                sel_cmd | sel_ioa | sel_bta | sel_iod | sel_stat;
  wire busy = (state == ST_WAIT);

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl)
      rd_mux[CTRL_CIRC_BIT] = circ_en;
    else if (sel_ptr)
      rd_mux[PTR_W-1:0] = coefficient_pointer;
    else if (sel_bsa)
      rd_mux[PTR_W-1:0] = coeff_buffer_start;
    else if (sel_page)
      rd_mux[PAGE_W-1:0] = peripheral_page_pointer;
    else if (sel_acc)
      rd_mux = accumulator_two;
    else if (sel_st0)
      rd_mux[ST0_TF2_BIT:ST0_TF1_BIT] = {test_flag_two, test_flag_one};
    else if (sel_ioa)
      rd_mux[PTR_W-1:0] = last_io_addr;
    else if (sel_bta)
      rd_mux[PTR_W-1:0] = last_bit_addr;
    else if (sel_iod)
      rd_mux[WORD_W-1:0] = io_data;
    else if (sel_stat)
      rd_mux[STAT_REFUSED_BIT:STAT_BUSY_BIT] = {refused, busy};
  end

  // No wait states: read data is captured in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata <= rd_mux;
      pslverr <= ~mapped;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire cmd_wr = wr_acc & sel_cmd;
  wire bagu_op_t op = bagu_op_t'(pwdata[CMD_OP_LSB +: CMD_OP_W]);
  wire [PTR_W-1:0] ext_word = pwdata[CMD_EXT_LSB +: PTR_W];
  wire [POFS_W-1:0] poffset = pwdata[CMD_POFS_LSB +: POFS_W];
  wire io_qual = pwdata[CMD_QUAL_BIT];
  wire io_we = pwdata[CMD_WRITE_BIT];
  wire par_issue = pwdata[CMD_PAR_BIT];
  wire is_io_op = (op == OP_IO_ABS) | (op == OP_IO_DIR) | (op == OP_IO_IND);
  wire ext_conflict = par_issue & uses_ext(op);
  // A new access while one is outstanding would lose the first
  wire cmd_refused = cmd_wr & (ext_conflict | (is_io_op & busy));
  wire cmd_go = cmd_wr & ~cmd_refused & (op != OP_NONE);

  // ----------------------------------------
  // Bit address path
  // ----------------------------------------
  // Pointer plus signed offset
  wire [PTR_W-1:0] ptr_sum = PTR_W'(coefficient_pointer + ext_word);
  wire [PTR_W-1:0] next_bit_addr = lin_or_circ(ptr_sum, circ_en, coeff_buffer_start);
  wire [BIDX_W-1:0] bidx = next_bit_addr[BIDX_W-1:0];
  wire [BIDX_W-1:0] bidx_pair = BIDX_W'(bidx + BIDX_ONE);
  wire is_pre = (op == OP_BIT_CLR_PRE) | (op == OP_BIT_TST_PRE);
  wire is_clr = (op == OP_BIT_CLR_OFS) | (op == OP_BIT_CLR_PRE);
  wire is_tst = (op == OP_BIT_TST_OFS) | (op == OP_BIT_TST_PRE);
  wire is_bit_op = is_pre | is_clr | is_tst;

  wire [SRC_W-1:0] clr_mask = ~(SRC_W'(1) << bidx);

  // ----------------------------------------
  // I/O address path
  // ----------------------------------------
  // Page in high bits, offset low
  wire [PTR_W-1:0] dir_addr = {peripheral_page_pointer, poffset};
  wire [PTR_W-1:0] ind_addr = lin_or_circ(coefficient_pointer, circ_en,
                                          coeff_buffer_start);
  logic [PTR_W-1:0] next_io_addr;
  logic next_io_space;
  always_comb
  begin
    next_io_addr = ind_addr;
    next_io_space = io_qual;
    if (op == OP_IO_ABS)
    begin
      next_io_addr = ext_word;
      next_io_space = 1'b1;
    end
    else if (op == OP_IO_DIR)
    begin
      next_io_addr = dir_addr;
    end
  end

  // ----------------------------------------
  // Registers written by software and by operations
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      circ_en <= 1'b0;
      coeff_buffer_start <= PTR_RST;
      peripheral_page_pointer <= PAGE_RST;
    end
    else if (wr_acc)
    begin
      if (sel_ctrl)
        circ_en <= pwdata[CTRL_CIRC_BIT];
      if (sel_bsa)
        coeff_buffer_start <= pwdata[PTR_W-1:0];
      if (sel_page)
        peripheral_page_pointer <= pwdata[PAGE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      coefficient_pointer <= PTR_RST;
    else if (cmd_go & is_pre)
      coefficient_pointer <= ptr_sum;
    else if (wr_acc & sel_ptr)
      coefficient_pointer <= pwdata[PTR_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      accumulator_two <= SRC_RST;
    else if (cmd_go & is_clr)
      accumulator_two <= accumulator_two & clr_mask;
    else if (wr_acc & sel_acc)
      accumulator_two <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_flag_one <= 1'b0;
      test_flag_two <= 1'b0;
    end
    else if (cmd_go & is_tst)
    begin
      test_flag_one <= accumulator_two[bidx];
      test_flag_two <= accumulator_two[bidx_pair];
    end
    else if (wr_acc & sel_st0)
    begin
      test_flag_one <= pwdata[ST0_TF1_BIT];
      test_flag_two <= pwdata[ST0_TF2_BIT];
    end
  end

  // Sticky refusal flag, write one to clear; a new refusal wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused <= 1'b0;
    else if (cmd_refused)
      refused <= 1'b1;
    else if (wr_acc & sel_stat & pwdata[STAT_REFUSED_BIT])
      refused <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_bit_addr <= PTR_RST;
    else if (cmd_go & is_bit_op)
      last_bit_addr <= next_bit_addr;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  wire io_start = cmd_go & is_io_op;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      mem_req <= '0;
      last_io_addr <= PTR_RST;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (io_start)
          begin
            state <= ST_WAIT;
            mem_req.req <= 1'b1;
            mem_req.io_space <= next_io_space;
            mem_req.we <= io_we;
            mem_req.addr <= next_io_addr;
            mem_req.wdata <= io_data;
            last_io_addr <= next_io_addr;
          end
        end
        ST_WAIT:
        begin
          if (mem_ack)
          begin
            state <= ST_IDLE;
            mem_req.req <= 1'b0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Data register: software write sets write data, an acked read returns here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      io_data <= '0;
    else if (busy & mem_ack & ~mem_req.we)
      io_data <= mem_rdata;
    else if (wr_acc & sel_iod & ~busy)
      io_data <= pwdata[WORD_W-1:0];
  end

endmodule : bagu_top

/* File: bench/bagu_top_sva.sv */
// Purpose: Port-level checker for bagu_top
// Assumes: One pclk domain, presetn async active low
// Notes: Sees only the top ports; bound at the foot of this file
`timescale 1ns/10ps
module bagu_top_sva
  import bagu_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memory and I/O port
  input wire bagu_mem_req_t mem_req,
  input wire logic [WORD_W-1:0] mem_rdata,
  input wire logic mem_ack
);
  // --------------------------------
  // Decode of the command write
  // --------------------------------
  wire logic acc = psel && penable;
  wire logic cmd_go = acc && pwrite && paddr == OFS_CMD && !mem_req.req;
  wire logic [2:0] op = pwdata[2:0];
  wire logic par = pwdata[CMD_PAR_BIT];
  wire logic mapped = paddr[1:0] == 2'h0 && paddr <= OFS_UNIT_STAT;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_req_hold: assert property (mem_req.req && !mem_ack |=> $stable(mem_req))
    else $error("request changed before ack");
  chk_req_drop: assert property (mem_req.req && mem_ack |=> !mem_req.req)
    else $error("request not dropped after ack");
  chk_abs_addr: assert property (cmd_go && op == OP_IO_ABS && !par |=>
    mem_req.req && mem_req.io_space && mem_req.addr == $past(pwdata[31:16]))
    else $error("absolute access wrong");
  chk_dir_addr: assert property (cmd_go && op == OP_IO_DIR |=>
    mem_req.addr[6:0] == $past(pwdata[14:8]) && mem_req.io_space == $past(pwdata[4]))
    else $error("direct access wrong");
  chk_par_block: assert property (cmd_go && par && op >= 3'h1 && op <= 3'h5 |=>
    !mem_req.req)
    else $error("parallel command issued");
  chk_dir_we: assert property (cmd_go && op >= 3'h6 |=>
    mem_req.req && mem_req.we == $past(pwdata[CMD_WRITE_BIT]))
    else $error("direction or request wrong");
  chk_no_spur: assert property (!mem_req.req && !cmd_go |=> !mem_req.req)
    else $error("request without command");
  chk_slv_err: assert property (acc |-> pslverr == !mapped)
    else $error("slave error wrong");
  chk_ready_on: assert property (pready)
    else $error("ready low");
endmodule : bagu_top_sva

bind bagu_top bagu_top_sva #(.ADDR_W(ADDR_W)) u_bagu_top_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

/* File: bench/bagu_io_model.sv */
// Purpose: Peripheral register responder on the I/O port
// Assumes: Same pclk as the block
// Notes: Read word is address xor 5aa5; data toggles outside ack
`timescale 1ns/10ps
module bagu_io_model
  import bagu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Access port
  input wire bagu_mem_req_t mem_req,
  input wire logic [7:0] wait_cyc,
  output logic [WORD_W-1:0] mem_rdata,
  output logic mem_ack,
  // Last access taken
  output bagu_mem_req_t seen
);
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      seen <= '0;
    end
    else if (mem_req.req && !mem_ack && cnt == wait_cyc)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_req.addr ^ 16'h5aa5;
      seen <= mem_req;
      cnt <= 8'h00;
    end
    else
    begin
      mem_ack <= 1'b0;
      // Inverted so a stale word is never mistaken for a fresh one
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req.req && !mem_ack) ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule : bagu_io_model

/* File: bench/bagu_top_bench.sv */
// Purpose: Self-checking bench for bagu_top
// Assumes: Responder model on the I/O port
// Notes: Random stimulus from a fixed seed plus corner cases
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, g, e); end end
module bagu_top_bench
  import bagu_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_ack, last_err, c;
  logic [7:0] paddr, wait_cyc;
  logic [31:0] pwdata, prdata, acc, junk;
  logic [15:0] mem_rdata, p, e, s, a, a1;
  logic [8:0] pg;
  logic [6:0] o;
  logic [2:0] op;
  bagu_mem_req_t mem_req, seen;
  int n_errors = 0;
  int checks = 0;
  integer seed = 32'hacb4;
  bagu_top u_bagu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  bagu_io_model u_bagu_io_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .wait_cyc(wait_cyc), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .seen(seen));
  // --------------------------------
  // Bus tasks
  // --------------------------------
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, junk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, ad, 32'h0, r);
    `CHK(r, x)
  endtask : rd_chk
  task automatic wait_idle;
    logic [31:0] r;
    r = 32'h1;
    for (int i = 0; i < 50 && r[STAT_BUSY_BIT] !== 1'b0; i++) apb(1'b0, OFS_UNIT_STAT, 0, r);
    `CHK(r[STAT_BUSY_BIT], 1'b0)
  endtask : wait_idle
  task automatic io_op(input logic [31:0] cmd, input logic [15:0] ea, input logic eio);
    logic [31:0] d;
    d = $random(seed);
    wr(OFS_IO_DATA, {16'h0, d[15:0]});
    wr(OFS_CMD, cmd);
    wait_idle();
    rd_chk(OFS_IO_ADDR, {16'h0, ea});
    `CHK(seen.addr, ea)
    `CHK(seen.io_space, eio)
    `CHK(seen.we, cmd[CMD_WRITE_BIT])
    if (cmd[CMD_WRITE_BIT]) `CHK(seen.wdata, d[15:0])
    else rd_chk(OFS_IO_DATA, {16'h0, ea ^ 16'h5aa5});
  endtask : io_op
  task automatic end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  function automatic logic [15:0] baddr(logic cc, logic [15:0] ss, logic [15:0] pp,
                                        logic [15:0] ee);
    return (cc ? ss : 16'h0) + pp + ee;
  endfunction : baddr
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wait_cyc} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_COEF_PTR, 32'h0);
    rd_chk(8'h30, 32'h0);
    `CHK(last_err, 1'b1)
    // Corner pointers first: bits 21/22 and the 31 to 0 wrap
    for (int i = 0; i < 16; i++)
    begin
      c = i[0];
      op = 3'h1 + 3'((i >> 1) % 4);
      s = (i < 8) ? 16'h0 : 16'($random(seed));
      p = (i < 8) ? 16'h0010 : 16'($random(seed));
      e = (i >= 8) ? 16'($random(seed)) : i[1] ? 16'h000f : 16'h0005;
      acc = $random(seed);
      wr(OFS_CTRL, {31'h0, c});
      wr(OFS_BUF_START, {16'h0, s});
      wr(OFS_COEF_PTR, {16'h0, p});
      wr(OFS_ACC_TWO, acc);
      wr(OFS_STATUS0, 32'h0);
      wr(OFS_CMD, {e, 13'h0, op});
      a = baddr(c, s, p, e);
      a1 = a + 16'h1;
      rd_chk(OFS_BIT_ADDR, {16'h0, a});
      rd_chk(OFS_COEF_PTR, {16'h0, (op == 3'h2 || op == 3'h4) ? p + e : p});
      if (op < 3'h3) rd_chk(OFS_ACC_TWO, acc & ~(32'h1 << a[4:0]));
      else rd_chk(OFS_STATUS0, {30'h0, acc[a1[4:0]], acc[a[4:0]]});
    end
    wr(OFS_ACC_TWO, 32'hffff_ffff);
    wr(OFS_CMD, 32'h0001_0041);
    rd_chk(OFS_ACC_TWO, 32'hffff_ffff);
    rd_chk(OFS_UNIT_STAT, 32'h2);
    wr(OFS_UNIT_STAT, 32'h2);
    wr(OFS_CMD, 32'hf000_0045);
    rd_chk(OFS_UNIT_STAT, 32'h2);
    wr(OFS_UNIT_STAT, 32'h2);
    rd_chk(OFS_UNIT_STAT, 32'h0);
    wr(OFS_PAGE_PTR, 32'h1ff);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COEF_PTR, 32'hff80);
    io_op(32'h0002_0005, 16'h0002, 1'b1);
    io_op(32'hf000_0025, 16'hf000, 1'b1);
    io_op(32'h0000_0016, 16'hff80, 1'b1);
    io_op(32'h0000_7f36, 16'hffff, 1'b1);
    io_op(32'h0000_1006, 16'hff90, 1'b0);
    io_op(32'h0000_0017, 16'hff80, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      pg = 9'($random(seed));
      o = 7'($random(seed));
      wr(OFS_PAGE_PTR, {23'h0, pg});
      io_op({16'h0, 1'b0, o, 8'h36}, {pg, o}, 1'b1);
    end
    wait_cyc <= 8'd20;
    wr(OFS_CMD, 32'h0005_0005);
    wr(OFS_CMD, 32'h0006_0005);
    rd_chk(OFS_UNIT_STAT, 32'h3);
    wait_idle();
    rd_chk(OFS_IO_ADDR, 32'h0005);
    end_sim();
  end
endmodule : bagu_top_bench
